// ---- rtl/optical_pkg.sv ----
// Shared constants for the optical transceiver control block.
package optical_pkg;
   localparam int CLK_FREQ_MHZ  = 100;
   localparam int OSC_PERIOD_NS = 100;
   localparam int OSC_CYCLES    = OSC_PERIOD_NS * CLK_FREQ_MHZ / 1000;

   localparam int TX_LOCK_MIN_NS = 700;
   localparam int TX_LOCK_MAX_NS = 1100;
   localparam int RX_LOCK_MIN_NS = 300;
   localparam int RX_LOCK_MAX_NS = 700;
   localparam int TX_HOLD_CYCLES = (TX_LOCK_MIN_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int RX_HOLD_CYCLES = (RX_LOCK_MIN_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int HOLD_W         = 7;

   localparam int ALARM_NOM_NS    = 2000;
   localparam int ALARM_MIN_NS    = 1900;
   localparam int ALARM_MAX_NS    = 2100;
   localparam int SYNC_NOM_NS     = 3000;
   localparam int SYNC_MIN_NS     = 2900;
   localparam int SYNC_MAX_NS     = 3100;
   localparam int ALARM_MIN_TICKS = (ALARM_MIN_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS;
   localparam int ALARM_MAX_TICKS = ALARM_MAX_NS / OSC_PERIOD_NS;
   localparam int SYNC_MIN_TICKS  = (SYNC_MIN_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS;
   localparam int SYNC_MAX_TICKS  = SYNC_MAX_NS / OSC_PERIOD_NS;

   localparam int STEADY_LIGHT_TIME_NS = 11400;
   localparam int STEADY_TICKS         = 114;
   localparam int TICK_W               = 7;

   localparam int RESET_STRETCH_US     = 3400;
   localparam int RESET_STRETCH_CYCLES = RESET_STRETCH_US * CLK_FREQ_MHZ;
   localparam int STRETCH_W            = 19;
   localparam int SLEEP_ENTRY_MIN_MS   = 10;
   localparam int SLEEP_ENTRY_MAX_MS   = 20;
   localparam int SLEEP_ENTRY_CYCLES   = SLEEP_ENTRY_MIN_MS * 1000 * CLK_FREQ_MHZ;
   localparam int SLEEP_W              = 20;
   localparam int WAKEUP_TIME_MS       = 10;
   localparam int WAKE_PULSES          = 8;
   localparam int PULSE_CNT_W          = 4;

   typedef enum logic [1:0] {
      MODE_STRETCH = 2'h0,
      MODE_ACTIVE  = 2'h1,
      MODE_SLEEP   = 2'h3,
      MODE_WAKE    = 2'h2
   } mode_type;
endpackage

// ---- rtl/pin_sync.sv ----
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter logic INIT = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic pin,
   output logic      level
);
   logic stage1_reg;
   logic stage2_reg;
   logic stage3_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         stage1_reg <= INIT;
         stage2_reg <= INIT;
         stage3_reg <= INIT;
         level      <= INIT;
      end else begin
         stage1_reg <= pin;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         if (stage2_reg == stage3_reg) begin
            level <= stage3_reg;
         end
      end
   end
endmodule
`default_nettype wire

// ---- rtl/pulse_classifier.sv ----
// Pulse width classifier counting oscillator ticks from each pulse start.
`timescale 1ns/1ps
`default_nettype none
module pulse_classifier (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic clear,
   input  wire logic oscTick,
   input  wire logic active,
   output logic      syncPulse,
   output logic      alarmPulse,
   output logic      pulseEnd,
   output logic      steadyHit
);
   localparam logic [optical_pkg::TICK_W-1:0] STEADY =
      optical_pkg::TICK_W'(optical_pkg::STEADY_TICKS);

   logic                        activePrev_reg;
   logic [optical_pkg::TICK_W-1:0] tickCnt_reg;
   logic                        ends;

   function automatic logic inWindow(input logic [optical_pkg::TICK_W-1:0] cnt,
                                     input int lo, input int hi);
      inWindow = (int'(cnt) >= lo) && (int'(cnt) <= hi);
   endfunction

   assign ends = activePrev_reg & ~active;

   // The count saturates so that a long pulse cannot wrap into a valid window.
   always_ff @(posedge clk) begin
      if (rst || clear) begin
         activePrev_reg <= 1'b0;
         tickCnt_reg    <= '0;
      end else begin
         activePrev_reg <= active;
         if (active && !activePrev_reg) begin
            tickCnt_reg <= '0;
         end else if (active && oscTick && tickCnt_reg != STEADY) begin
            tickCnt_reg <= tickCnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst || clear) begin
         syncPulse  <= 1'b0;
         alarmPulse <= 1'b0;
         pulseEnd   <= 1'b0;
         steadyHit  <= 1'b0;
      end else begin
         alarmPulse <= ends && inWindow(tickCnt_reg, optical_pkg::ALARM_MIN_TICKS,
                                        optical_pkg::ALARM_MAX_TICKS);
         syncPulse  <= ends && inWindow(tickCnt_reg, optical_pkg::SYNC_MIN_TICKS,
                                        optical_pkg::SYNC_MAX_TICKS);
         pulseEnd   <= ends;
         steadyHit  <= active && tickCnt_reg == STEADY;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/optical_transceiver_control.sv ----
// Top level of the half-duplex optical transceiver control logic.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Low transmit input lights the emitter; high turns it off.
// - Received light drives the receive output low, darkness high.
// - Receive output is push-pull, active low, blockable by transmit lock.
// - Transmit input is inverted and gated by the receive lock.
// - Activity on one path blocks the other, held after the edge, retriggerable.
// - Hold after transmit activity lasts 700 to 1100 ns.
// - Hold after receive activity lasts 300 to 700 ns.
// - Continuous light removes the lock on the transmit path.
// - A 1900 to 2100 ns pulse is an alarm and sets the alarm output.
// - A 2900 to 3100 ns pulse is a sync pulse.
// - Alarm clears on sync, power-on, continuous light and sleep entry.
// - Alarm is accepted only after a sync since power-on or wake-up.
// - Continuous light is declared after 114 oscillator periods.
// - Power-on resets all units, enters normal mode, alarm inactive; the hold counters, transmit classifier and time base are not reset by it.
// - Reset is stretched 3.4 ms with both outputs locked.
// - Sync pulses pass unchanged and clear a pending alarm.
// - Further alarms keep the alarm set; data flows as normal.
// - Continuous light blocks the receive output and clears the alarm.
// - Output unblocks after a valid sync or alarm without continuous light.
// - After the sleep-entry time with dark or steady light, enter sleep.
// - Sleep-entry time from the last transmitted bit is 10 to 20 ms.
// - Active mode follows within 10 ms of the first wake-up pattern.
// - Wake-up acts as a reset stretched by 3.4 ms.
// - After wake-up, continuous light detection waits for 8 pulses.
// - A falling transmit input wakes at once and passes to the emitter.
module optical_transceiver_control #(
   parameter logic [optical_pkg::STRETCH_W-1:0] RESET_STRETCH =
      optical_pkg::STRETCH_W'(optical_pkg::RESET_STRETCH_CYCLES),
   parameter logic [optical_pkg::SLEEP_W-1:0]   SLEEP_ENTRY   =
      optical_pkg::SLEEP_W'(optical_pkg::SLEEP_ENTRY_CYCLES)
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic txDataIn,
   input  wire logic lightDetected,
   input  wire logic powerOnPulse,
   input  wire logic wakeupDetect,
   output logic      emitterDriveOut,
   output logic      rxDataOut,
   output logic      alarmOut,
   output logic      alarmOe,
   output logic      sleepMode
);
   localparam logic [optical_pkg::HOLD_W-1:0] TX_HOLD =
      optical_pkg::HOLD_W'(optical_pkg::TX_HOLD_CYCLES);
   localparam logic [optical_pkg::HOLD_W-1:0] RX_HOLD =
      optical_pkg::HOLD_W'(optical_pkg::RX_HOLD_CYCLES);
   localparam logic [optical_pkg::TICK_W-1:0] OSC_LAST =
      optical_pkg::TICK_W'(optical_pkg::OSC_CYCLES - 1);
   localparam logic [optical_pkg::PULSE_CNT_W-1:0] WAKE_PULSES =
      optical_pkg::PULSE_CNT_W'(optical_pkg::WAKE_PULSES);
   localparam int TxHold   = optical_pkg::TX_HOLD_CYCLES;
   localparam int TxHoldP1 = optical_pkg::TX_HOLD_CYCLES + 1;
   localparam int RxHold   = optical_pkg::RX_HOLD_CYCLES;
   localparam int RxHoldP1 = optical_pkg::RX_HOLD_CYCLES + 1;

   logic                         txSync;
   logic                         lightSync;
   logic                         ponSync;
   logic                         wakeSync;
   logic                         txPrev_reg;
   logic                         txFall;
   logic                         txActive;

   optical_pkg::mode_type        mode_reg;
   logic [optical_pkg::STRETCH_W-1:0] stretchCnt_reg;
   logic [optical_pkg::SLEEP_W-1:0]   sleepCnt_reg;
   logic                         enterSleep;
   logic                         isActive;

   logic [optical_pkg::TICK_W-1:0] oscCnt_reg;
   logic                         oscTick;

   logic [optical_pkg::HOLD_W-1:0] txHoldCnt_reg;
   logic [optical_pkg::HOLD_W-1:0] rxHoldCnt_reg;
   logic                         txPassReg;
   logic                         rxPassReg;
   logic                         txHoldActive;
   logic                         rxHoldActive;
   logic                         txPass;
   logic                         rxPass;
   logic                         emitLock;

   logic                         rxSyncPulse;
   logic                         rxAlarmPulse;
   logic                         rxPulseEnd;
   logic                         rxSteadyHit;
   logic                         txSyncPulse;
   logic                         txAlarmPulse;
   logic                         steadyEn_reg;
   logic [optical_pkg::PULSE_CNT_W-1:0] pulseCnt_reg;
   logic                         steadyNow;
   logic                         outBlock_reg;
   logic                         syncSeen_reg;

   pin_sync #(.INIT(1'b1)) txSyncInst (
      .clk   (clk),
      .rst   (rst),
      .pin   (txDataIn),
      .level (txSync)
   );
   pin_sync #(.INIT(1'b0)) lightSyncInst (
      .clk   (clk),
      .rst   (rst),
      .pin   (lightDetected),
      .level (lightSync)
   );
   pin_sync #(.INIT(1'b0)) ponSyncInst (
      .clk   (clk),
      .rst   (rst),
      .pin   (powerOnPulse),
      .level (ponSync)
   );
   pin_sync #(.INIT(1'b0)) wakeSyncInst (
      .clk   (clk),
      .rst   (rst),
      .pin   (wakeupDetect),
      .level (wakeSync)
   );

   assign txActive = ~txSync;
   assign txFall   = txPrev_reg & ~txSync;
   assign isActive = (mode_reg == optical_pkg::MODE_ACTIVE);
   assign oscTick  = (oscCnt_reg == OSC_LAST);

   // Local time base standing in for the trimmed internal oscillator.
   always_ff @(posedge clk) begin
      if (rst || oscTick) begin
         oscCnt_reg <= '0;
      end else begin
         oscCnt_reg <= oscCnt_reg + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         txPrev_reg <= 1'b1;
      end else begin
         txPrev_reg <= txSync;
      end
   end

   // Mode control: stretch after power-on, normal, sleep, stretch after wake-up.
   always_ff @(posedge clk) begin
      if (rst || ponSync) begin
         mode_reg       <= optical_pkg::MODE_STRETCH;
         stretchCnt_reg <= RESET_STRETCH;
      end else begin
         case (mode_reg)
            optical_pkg::MODE_STRETCH, optical_pkg::MODE_WAKE: begin
               if (stretchCnt_reg == '0) begin
                  mode_reg <= optical_pkg::MODE_ACTIVE;
               end else begin
                  stretchCnt_reg <= stretchCnt_reg - 1'b1;
               end
            end
            optical_pkg::MODE_ACTIVE: begin
               if (enterSleep) begin
                  mode_reg <= optical_pkg::MODE_SLEEP;
               end
            end
            optical_pkg::MODE_SLEEP: begin
               // The stretch is far shorter than the wake-up time allowed.
               if (wakeSync || txFall) begin
                  mode_reg       <= optical_pkg::MODE_WAKE;
                  stretchCnt_reg <= RESET_STRETCH;
               end
            end
            default: begin
               mode_reg <= optical_pkg::MODE_STRETCH;
            end
         endcase
      end
   end

   // Sleep timer restarts on each transmitted bit and on ordinary received light.
   always_ff @(posedge clk) begin
      if (rst || !isActive || txActive || (lightSync && !rxSteadyHit)) begin
         sleepCnt_reg <= '0;
      end else if (!enterSleep) begin
         sleepCnt_reg <= sleepCnt_reg + 1'b1;
      end
   end
   assign enterSleep = isActive && (sleepCnt_reg == SLEEP_ENTRY - 1'b1);

   always_ff @(posedge clk) begin
      if (rst) begin
         sleepMode <= 1'b0;
      end else begin
         sleepMode <= (mode_reg == optical_pkg::MODE_SLEEP);
      end
   end

   // Mutual lock. The transmit side wins a tie, so both paths never stall each other.
   assign emitLock     = (mode_reg == optical_pkg::MODE_STRETCH) || ponSync;
   assign txHoldActive = txPassReg || (txHoldCnt_reg != '0);
   assign rxHoldActive = rxPassReg || (rxHoldCnt_reg != '0);
   assign txPass = txActive && !emitLock && !(rxHoldActive && !steadyNow);
   assign rxPass = lightSync && isActive && !emitLock && !txHoldActive && !txPass;

   always_ff @(posedge clk) begin
      if (rst) begin
         txPassReg     <= 1'b0;
         txHoldCnt_reg <= '0;
      end else begin
         txPassReg <= txPass;
         if (txPassReg) begin
            txHoldCnt_reg <= TX_HOLD;
         end else if (txHoldCnt_reg != '0) begin
            txHoldCnt_reg <= txHoldCnt_reg - 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rxPassReg     <= 1'b0;
         rxHoldCnt_reg <= '0;
      end else begin
         rxPassReg <= rxPass;
         if (rxPassReg) begin
            rxHoldCnt_reg <= RX_HOLD;
         end else if (rxHoldCnt_reg != '0) begin
            rxHoldCnt_reg <= rxHoldCnt_reg - 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         emitterDriveOut <= 1'b0;
         rxDataOut       <= 1'b1;
      end else begin
         emitterDriveOut <= txPass;
         rxDataOut       <= ~(rxPass && !outBlock_reg);
      end
   end

   pulse_classifier rxClassInst (
      .clk        (clk),
      .rst        (rst),
      .clear      (!isActive),
      .oscTick    (oscTick),
      .active     (lightSync),
      .syncPulse  (rxSyncPulse),
      .alarmPulse (rxAlarmPulse),
      .pulseEnd   (rxPulseEnd),
      .steadyHit  (rxSteadyHit)
   );
   pulse_classifier txClassInst (
      .clk        (clk),
      .rst        (rst),
      .clear      (mode_reg == optical_pkg::MODE_SLEEP),
      .oscTick    (oscTick),
      .active     (txActive),
      .syncPulse  (txSyncPulse),
      .alarmPulse (txAlarmPulse),
      .pulseEnd   (),
      .steadyHit  ()
   );

   // Steady light detection is held off after wake-up until enough pulses arrive.
   always_ff @(posedge clk) begin
      if (rst || ponSync) begin
         steadyEn_reg <= 1'b1;
         pulseCnt_reg <= '0;
      end else if (mode_reg == optical_pkg::MODE_WAKE) begin
         steadyEn_reg <= 1'b0;
         pulseCnt_reg <= '0;
      end else if (isActive && rxPulseEnd && !steadyEn_reg) begin
         pulseCnt_reg <= pulseCnt_reg + 1'b1;
         steadyEn_reg <= (pulseCnt_reg == WAKE_PULSES - 1'b1);
      end
   end
   assign steadyNow = rxSteadyHit && steadyEn_reg;

   // Output block: the set wins over a clear in the same cycle.
   always_ff @(posedge clk) begin
      if (rst || !isActive) begin
         outBlock_reg <= 1'b0;
      end else if (steadyNow) begin
         outBlock_reg <= 1'b1;
      end else if ((rxSyncPulse || rxAlarmPulse || txSyncPulse || txAlarmPulse)
                   && !rxSteadyHit) begin
         outBlock_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || !isActive) begin
         syncSeen_reg <= 1'b0;
      end else if (rxSyncPulse) begin
         syncSeen_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || !isActive || enterSleep || steadyNow) begin
         alarmOe <= 1'b0;
      end else if (rxAlarmPulse && syncSeen_reg) begin
         alarmOe <= 1'b1;
      end else if (rxSyncPulse) begin
         alarmOe <= 1'b0;
      end
   end
   // Open-drain: the pin is only ever pulled low.
   assign alarmOut = 1'b0;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   emitterOn_a: assert property (emitterDriveOut |-> $past(txActive))
      else $error("emitter lit without a low transmit input");
   rxLow_a: assert property (!rxDataOut |-> $past(lightSync) && !$past(txPass))
      else $error("receive output low without light or while transmitting");
   rxLocked_a: assert property (txHoldActive |=> rxDataOut)
      else $error("receive output active while transmit lock holds");
   txRelease_a: assert property ($fell(txHoldActive) |->
                                 $past(txPassReg, TxHoldP1) && !$past(txPassReg, TxHold))
      else $error("receive lock released at the wrong time");
   rxRelease_a: assert property ($fell(rxHoldActive) |->
                                 $past(rxPassReg, RxHoldP1) && !$past(rxPassReg, RxHold))
      else $error("transmit lock released at the wrong time");
   steadyTx_a: assert property (steadyNow && txActive && !emitLock |=> emitterDriveOut)
      else $error("transmit blocked during continuous light");
   alarmSet_a: assert property (rxAlarmPulse && syncSeen_reg && isActive && !enterSleep
                                && !steadyNow |=> alarmOe)
      else $error("alarm pulse did not raise the alarm");
   alarmClear_a: assert property (rxSyncPulse |=> !alarmOe)
      else $error("sync pulse did not clear the alarm");
   noEarlyAlarm_a: assert property (!syncSeen_reg && !alarmOe |=> !alarmOe)
      else $error("alarm raised before any sync pulse");
   steadyBlock_a: assert property (steadyNow |=> outBlock_reg && !alarmOe ##1 rxDataOut)
      else $error("continuous light did not block the output");
   stretchLock_a: assert property (emitLock |=> rxDataOut && !emitterDriveOut)
      else $error("outputs not locked during reset stretch");
   sleepAlarm_a: assert property (enterSleep && !ponSync |=> !alarmOe ##1 sleepMode)
      else $error("sleep entry left alarm on or did not sleep");
   wakeTx_a: assert property (sleepMode && txFall |-> ##[1:2] !sleepMode)
      else $error("falling transmit input did not wake the device");

   alarmRaised_c: cover property (syncSeen_reg ##[1:1000] $rose(alarmOe));
   steadySeen_c: cover property ($rose(outBlock_reg));
   sleepWake_c: cover property (sleepMode ##[1:100] !sleepMode);
   lockTurn_c: cover property ($fell(txHoldActive) ##[1:200] rxPassReg);
endmodule
`default_nettype wire

// ---- sim/bus_ctrl_model.sv ----
// Behavioural bus protocol controller that drives the transmit pin of the block.
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_model (
   input  wire logic clk,
   input  wire logic rxDataOut,
   output var logic  txDataIn
);
   initial txDataIn = 1'h1;

   // The pin idles high through the controller's pull-up, so light stays off between frames.
   task automatic drive(input logic level);
      txDataIn <= level;
   endtask

   // Frame contents right after a wake-up are not trusted, so callers compare levels only.
   task automatic pulse(input int n);
      txDataIn <= 1'h0;
      repeat (n) @(posedge clk);
      txDataIn <= 1'h1;
   endtask
endmodule
`default_nettype wire

// ---- sim/optical_transceiver_control_tb.sv ----
// Self-checking testbench for the optical transceiver control block.
`timescale 1ns/1ps
`default_nettype none
module optical_transceiver_control_tb;
   localparam logic [18:0] STRETCH = 19'h00014;
   localparam logic [19:0] SLEEP   = 20'h007D0;
   logic clk           = 1'h0;
   logic rst;
   logic lightDetected;
   logic powerOnPulse;
   logic wakeupDetect;
   logic txDataIn;
   logic emitterDriveOut;
   logic rxDataOut;
   logic alarmOut;
   logic alarmOe;
   logic sleepMode;
   int   mismatches;
   int   compares;

   optical_transceiver_control #(
      .RESET_STRETCH(STRETCH),
      .SLEEP_ENTRY  (SLEEP)
   ) i_dut (
      .clk            (clk),
      .rst            (rst),
      .txDataIn       (txDataIn),
      .lightDetected  (lightDetected),
      .powerOnPulse   (powerOnPulse),
      .wakeupDetect   (wakeupDetect),
      .emitterDriveOut(emitterDriveOut),
      .rxDataOut      (rxDataOut),
      .alarmOut       (alarmOut),
      .alarmOe        (alarmOe),
      .sleepMode      (sleepMode)
   );

   bus_ctrl_model i_ctrl (
      .clk      (clk),
      .rxDataOut(rxDataOut),
      .txDataIn (txDataIn)
   );

   always #5 clk = ~clk;

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic check(input string name, input logic exp, input logic seen);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %b, seen %b", name, exp, seen);
      end
   endtask

   // A light pulse of n cycles; the receive level is judged halfway through.
   task automatic rxPulse(input int n, input logic expRx);
      lightDetected <= 1'h1;
      cyc(n / 2);
      check("rxData", expRx, rxDataOut);
      cyc(n - n / 2);
      lightDetected <= 1'h0;
      cyc(100);
   endtask

   task automatic summarize();
      $display("compares %0d, mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic testReset();
      i_ctrl.drive(1'h0);
      cyc(10);
      check("emitter", 1'h0, emitterDriveOut);
      check("rxData", 1'h1, rxDataOut);
      check("alarm", 1'h0, alarmOe);
      check("alarmPin", 1'h0, alarmOut);
      cyc(30);
      check("emitter", 1'h1, emitterDriveOut);
      i_ctrl.drive(1'h1);
      cyc(8);
      check("emitter", 1'h0, emitterDriveOut);
      cyc(100);
   endtask

   // The second short transmit pulse must restart the hold, or the light would pass early.
   task automatic testLocks();
      lightDetected <= 1'h1;
      cyc(10);
      i_ctrl.drive(1'h0);
      cyc(10);
      check("emitter", 1'h0, emitterDriveOut);
      lightDetected <= 1'h0;
      cyc(12);
      check("emitter", 1'h0, emitterDriveOut);
      cyc(40);
      check("emitter", 1'h1, emitterDriveOut);
      i_ctrl.drive(1'h1);
      cyc(50);
      i_ctrl.pulse(5);
      cyc(40);
      lightDetected <= 1'h1;
      cyc(15);
      check("rxData", 1'h1, rxDataOut);
      cyc(80);
      check("rxData", 1'h0, rxDataOut);
      lightDetected <= 1'h0;
      cyc(100);
   endtask

   task automatic testAlarm();
      rxPulse(200, 1'h0);
      check("alarm", 1'h0, alarmOe);
      rxPulse(300, 1'h0);
      rxPulse(250, 1'h0);
      check("alarm", 1'h0, alarmOe);
      rxPulse(200, 1'h0);
      check("alarm", 1'h1, alarmOe);
      rxPulse(200, 1'h0);
      check("alarm", 1'h1, alarmOe);
      rxPulse(300, 1'h0);
      check("alarm", 1'h0, alarmOe);
      rxPulse(200, 1'h0);
      check("alarm", 1'h1, alarmOe);
      powerOnPulse <= 1'h1;
      i_ctrl.drive(1'h0);
      cyc(10);
      check("alarm", 1'h0, alarmOe);
      check("emitter", 1'h0, emitterDriveOut);
      powerOnPulse <= 1'h0;
      i_ctrl.drive(1'h1);
      cyc(40);
      rxPulse(200, 1'h0);
      check("alarm", 1'h0, alarmOe);
   endtask

   task automatic testSteady();
      repeat (8) rxPulse(30, 1'h0);
      rxPulse(300, 1'h0);
      rxPulse(200, 1'h0);
      lightDetected <= 1'h1;
      cyc(1100);
      check("alarm", 1'h1, alarmOe);
      cyc(100);
      check("alarm", 1'h0, alarmOe);
      check("rxData", 1'h1, rxDataOut);
      i_ctrl.drive(1'h0);
      cyc(10);
      check("emitter", 1'h1, emitterDriveOut);
      i_ctrl.drive(1'h1);
      lightDetected <= 1'h0;
      cyc(100);
      rxPulse(50, 1'h1);
      i_ctrl.pulse(300);
      cyc(120);
      rxPulse(50, 1'h0);
   endtask

   task automatic testSleep();
      rxPulse(300, 1'h0);
      rxPulse(200, 1'h0);
      cyc(1700);
      check("sleep", 1'h0, sleepMode);
      check("alarm", 1'h1, alarmOe);
      cyc(300);
      check("sleep", 1'h1, sleepMode);
      check("alarm", 1'h0, alarmOe);
      i_ctrl.drive(1'h0);
      cyc(8);
      check("sleep", 1'h0, sleepMode);
      check("emitter", 1'h1, emitterDriveOut);
      i_ctrl.drive(1'h1);
      cyc(2100);
      check("sleep", 1'h1, sleepMode);
      repeat (4) begin
         lightDetected <= 1'h1;
         cyc(3);
         lightDetected <= 1'h0;
         cyc(3);
      end
      wakeupDetect <= 1'h1;
      lightDetected <= 1'h1;
      cyc(12);
      check("sleep", 1'h0, sleepMode);
      check("rxData", 1'h1, rxDataOut);
      wakeupDetect <= 1'h0;
      cyc(1300);
      check("rxData", 1'h0, rxDataOut);
      lightDetected <= 1'h0;
      cyc(100);
      // The long pulse above counts as the first of eight, so seven more re-arm the detector.
      repeat (7) rxPulse(30, 1'h0);
      lightDetected <= 1'h1;
      cyc(1200);
      check("rxData", 1'h1, rxDataOut);
      lightDetected <= 1'h0;
      cyc(100);
   endtask

   initial begin
      rst           <= 1'h1;
      lightDetected <= 1'h0;
      powerOnPulse  <= 1'h0;
      wakeupDetect  <= 1'h0;
      cyc(16);
      rst <= 1'h0;
      testReset();
      testLocks();
      testAlarm();
      testSteady();
      testSleep();
      summarize();
   end

   // The scenarios take about 15500 cycles, so a hang is cut at about twice that.
   initial begin
      #300000;
      mismatches++;
      summarize();
   end
endmodule
`default_nettype wire
